// File: hdl/fsf_pkg.sv
// Constants and types shared by the FIFO status flag block
// How it works
// RQ1: Fall-through: output-ready high only while a new word sits in output register.
// RQ2: Standard: empty flag high when RAM holds a readable word; else reads ignored.
// RQ3: Empty/output-ready flag on read clock; read pointer advances per output load.
// RQ4: Fall-through: first word loads and output-ready rises on third read edge.
// RQ5: Standard: empty flag rises on second read edge after a write.
// RQ6: Read edge counts as first sync cycle only after first skew margin.
// RQ7: Full/input-ready high while a location is free; writes ignored while low.
// RQ8: Full/input-ready flag on write clock; write pointer advances per accepted write.
// RQ9: Full/input-ready rises on second write edge after the freeing read.
// RQ10: Write edge counts as first sync cycle only after first skew margin.
// RQ11: Almost-empty on port B clock: low at offset words or fewer, else high.
// RQ12: Almost-empty rises on second port B edge after the filling write.
// RQ13: Almost-empty first sync edge must follow the write by second skew margin.
// RQ14: Almost-full low when count reaches depth minus offset, high below it.
// RQ15: Almost-full rises on second port A edge after the reducing read.
// RQ16: Almost-full first sync edge must follow the read by second skew margin.
// RQ17: Thresholds come from empty and full offset registers, preset at reset.
// RQ18: Timing select sampled at second edge after reset: high standard, low fall-through.
// RQ19: Every flag passes two flip-flop stages of its own port clock.
// RQ20: Reset clears pointers, empty and almost-empty low, almost-full high.
package fsf_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int DATA_W    = 36;
  localparam int DEPTH_DEF = 1024;
  localparam int OFS_W_DEF = 10;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [11:0] ADDR_STATUS    = 12'h000;
  localparam logic [11:0] ADDR_EMPTY_OFS = 12'h004;
  localparam logic [11:0] ADDR_FULL_OFS  = 12'h008;
  localparam logic [11:0] ADDR_FILL      = 12'h00C;

  // Status field positions
  localparam int ST_EOR_BIT          = 0;
  localparam int ST_IN_READY_BIT     = 1;
  localparam int ST_ALMOST_EMPTY_BIT = 2;
  localparam int ST_ALMOST_FULL_BIT  = 3;
  localparam int ST_FALL_THROUGH_BIT = 4;
  localparam int ST_RUN_BIT          = 5;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam int OFS_PRESET = 64;

  typedef struct packed {
    logic eor;                       // empty_or_output_ready_flag
    logic full_or_input_ready_flag;  // Write side has room
    logic almost_empty_flag;         // Above empty offset
    logic almost_full_flag;          // High while not almost full
  } fsf_flags_s;

  localparam fsf_flags_s FLAGS_RST = '{eor: 1'b0, full_or_input_ready_flag: 1'b0,
                                       almost_empty_flag: 1'b0, almost_full_flag: 1'b1};

  typedef enum {MS_RESET, MS_ARMED, MS_RUN} fsf_mode_e;

endpackage : fsf_pkg

// File: hdl/fsf_ram.sv
// Word memory of the FIFO with a registered read port
`timescale 1ns/1ps
module fsf_ram import fsf_pkg::*; #(
  parameter int W  = DATA_W,
  parameter int AW = OFS_W_DEF
) (
  input  wire logic          clk,     // Clock
  input  wire logic          rst_n,   // Async reset, active low
  input  wire logic          we,      // Write strobe
  input  wire logic [AW-1:0] waddr,   // Write address
  input  wire logic [W-1:0]  wdata,   // Write data
  input  wire logic          re,      // Load read register
  input  wire logic [AW-1:0] raddr,   // Read address
  output logic      [W-1:0]  rdata_q  // Read register
);

  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [W-1:0] rdata_d;

  always_comb begin
    rdata_d = re ? mem[raddr] : rdata_q;
  end

  // Memory array left without reset so it maps to RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule : fsf_ram

// File: hdl/fsf_top.sv
// FIFO with status flag logic and an APB register slave
`timescale 1ns/1ps
module fsf_top import fsf_pkg::*; #(
  parameter int DEPTH = DEPTH_DEF,
  parameter int AW    = OFS_W_DEF
) (
  input  wire logic              pclk,                 // Clock
  input  wire logic              presetn,              // Async reset, active low
  input  wire logic              psel,                 // APB select
  input  wire logic              penable,              // APB enable
  input  wire logic              pwrite,               // APB direction
  input  wire logic [11:0]       paddr,                // APB byte address
  input  wire logic [31:0]       pwdata,               // APB write data
  output logic      [31:0]       prdata,               // APB read data
  output logic                   pready,               // APB ready
  output logic                   pslverr,              // APB error
  input  wire logic              endian_timing_select, // Mode strap
  input  wire logic              wr_en,                // Write request
  input  wire logic [DATA_W-1:0] wr_data,              // Write word
  input  wire logic              rd_en,                // Read request
  output logic      [DATA_W-1:0] rd_data,              // Output register
  output fsf_flags_s             flags                 // Status flags
);

  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  // ************************************************************
  // State
  // ************************************************************
  fsf_mode_e    mode_q,  mode_d;
  logic         fall_through_q, fall_through_d;
  logic [PW-1:0] wptr_q, wptr_d;
  logic [PW-1:0] rptr_q, rptr_d;
  logic [PW-1:0] wp_dly_q, wp_dly_d;
  logic [PW-1:0] rp_dly_q, rp_dly_d;
  logic         nempty_q, nempty_d;
  fsf_flags_s   flags_q, flags_d;
  logic [AW-1:0] ofs_empty_q, ofs_empty_d;
  logic [AW-1:0] ofs_full_q,  ofs_full_d;
  logic [31:0]  prdata_q, prdata_d;
  logic         pready_q, pready_d;
  logic         pslverr_q, pslverr_d;

  logic          run;
  logic          wr_acc;
  logic          load;
  logic [PW-1:0] fill_r;
  logic [PW-1:0] fill_w;
  logic          apb_wr;
  logic          hit;

  assign run = (mode_q == MS_RUN);

  // ************************************************************
  // Mode selection after reset
  // ************************************************************
  always_comb begin
    mode_d = mode_q;
    fall_through_d = fall_through_q;
    case (mode_q)
      MS_RESET: mode_d = MS_ARMED;
      MS_ARMED: begin
        mode_d = MS_RUN;                           // [RQ18]
        fall_through_d = ~endian_timing_select;    // [RQ18]
      end
      MS_RUN:   mode_d = MS_RUN;
      default:  mode_d = MS_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q         <= MS_RESET;
      fall_through_q <= 1'b0;
    end else begin
      mode_q         <= mode_d;
      fall_through_q <= fall_through_d;
    end
  end

  // ************************************************************
  // Pointers and flags
  // ************************************************************
  // One clock serves both ports here, so the pointer copies below are
  // plain delay stages that reproduce the two-edge flag latency.
  always_comb begin
    wr_acc   = run & wr_en & flags_q.full_or_input_ready_flag;     // [RQ7]
    wptr_d   = wptr_q + PW'(wr_acc);                        // [RQ8]
    if (fall_through_q) begin
      load = run & nempty_q & (~flags_q.eor | rd_en);       // [RQ1] [RQ4]
    end else begin
      load = run & rd_en & flags_q.eor;                     // [RQ2]
    end
    rptr_d   = rptr_q + PW'(load);                          // [RQ3]
    wp_dly_d = wptr_q;                                      // [RQ6] [RQ13] [RQ19]
    rp_dly_d = rptr_q;                                      // [RQ10] [RQ16] [RQ19]
    fill_r   = wp_dly_q - rptr_d;
    fill_w   = wptr_d - rp_dly_q;
    nempty_d = (fill_r != '0);
    flags_d  = flags_q;
    if (fall_through_q) begin
      // Output-ready follows the third edge: delay, compare, load
      flags_d.eor = load | (flags_q.eor & ~rd_en);         // [RQ1] [RQ4]
    end else begin
      flags_d.eor = nempty_d;                               // [RQ2] [RQ5]
    end
    flags_d.full_or_input_ready_flag = run & (fill_w != DEPTH_P); // [RQ7] [RQ9]
    flags_d.almost_empty_flag = (fill_r > {1'b0, ofs_empty_q}); // [RQ11] [RQ12] [RQ17]
    flags_d.almost_full_flag = (fill_w < (DEPTH_P - {1'b0, ofs_full_q})); // [RQ14] [RQ15] [RQ17]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q   <= '0;                                       // [RQ20]
      rptr_q   <= '0;                                       // [RQ20]
      wp_dly_q <= '0;
      rp_dly_q <= '0;
      nempty_q <= 1'b0;
      flags_q  <= FLAGS_RST;                                // [RQ20]
    end else begin
      wptr_q   <= wptr_d;
      rptr_q   <= rptr_d;
      wp_dly_q <= wp_dly_d;
      rp_dly_q <= rp_dly_d;
      nempty_q <= nempty_d;
      flags_q  <= flags_d;
    end
  end

  assign flags = flags_q;

  fsf_ram #(
    .W  (DATA_W),
    .AW (AW)
  ) u_ram (
    .clk     (pclk),
    .rst_n   (presetn),
    .we      (wr_acc),
    .waddr   (wptr_q[AW-1:0]),
    .wdata   (wr_data),
    .re      (load),                                        // [RQ3]
    .raddr   (rptr_q[AW-1:0]),
    .rdata_q (rd_data)
  );

  // ************************************************************
  // APB register slave
  // ************************************************************
  // Answer is prepared in the setup cycle, so every access ends after
  // exactly one access cycle with no wait states.
  always_comb begin
    apb_wr      = psel & penable & pready_q & pwrite;
    hit         = (paddr == ADDR_STATUS) | (paddr == ADDR_EMPTY_OFS) |
                  (paddr == ADDR_FULL_OFS) | (paddr == ADDR_FILL);
    ofs_empty_d = ofs_empty_q;
    ofs_full_d  = ofs_full_q;
    if (apb_wr && paddr == ADDR_EMPTY_OFS) begin
      ofs_empty_d = pwdata[AW-1:0];                         // [RQ17]
    end
    if (apb_wr && paddr == ADDR_FULL_OFS) begin
      ofs_full_d = pwdata[AW-1:0];                          // [RQ17]
    end
    pready_d  = psel & ~penable;
    pslverr_d = psel & ~penable & ~hit;
    prdata_d  = prdata_q;
    if (psel && !penable) begin
      prdata_d = '0;
      if (!pwrite) begin
        case (paddr)
          ADDR_STATUS: begin
            prdata_d[ST_EOR_BIT]          = flags_q.eor;
            prdata_d[ST_IN_READY_BIT]     = flags_q.full_or_input_ready_flag;
            prdata_d[ST_ALMOST_EMPTY_BIT] = flags_q.almost_empty_flag;
            prdata_d[ST_ALMOST_FULL_BIT]  = flags_q.almost_full_flag;
            prdata_d[ST_FALL_THROUGH_BIT] = fall_through_q;
            prdata_d[ST_RUN_BIT]          = run;
          end
          ADDR_EMPTY_OFS: prdata_d[AW-1:0] = ofs_empty_q;
          ADDR_FULL_OFS:  prdata_d[AW-1:0] = ofs_full_q;
          ADDR_FILL:      prdata_d[PW-1:0] = wptr_q - rptr_q;
          default:        prdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ofs_empty_q <= AW'(OFS_PRESET);                       // [RQ17]
      ofs_full_q  <= AW'(OFS_PRESET);                       // [RQ17]
      prdata_q    <= '0;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
    end else begin
      ofs_empty_q <= ofs_empty_d;
      ofs_full_q  <= ofs_full_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule : fsf_top

// File: tb/fsf_asserts.sv
// Flag timing checks bound to the FIFO top
`timescale 1ns/1ps
module fsf_asserts import fsf_pkg::*; (
  input wire logic       pclk,    // Clock
  input wire logic       presetn, // Reset
  input wire logic       psel,    // Select
  input wire logic       penable, // Enable
  input wire logic       pready,  // Ready
  input wire logic       endian_timing_select, // Mode
  input wire logic       wr_en,   // Write
  input wire logic       rd_en,   // Read
  input wire fsf_flags_s flags    // Flags
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write into an empty FIFO, no other write in flight
  sequence s_lone_wr;
    wr_en && flags.full_or_input_ready_flag && !flags.eor && !$past(wr_en)
      && !$past(wr_en, 2) && !$past(wr_en, 3);
  endsequence
  property p_rst; $rose(presetn) |-> flags == FLAGS_RST; endproperty
  property p_std_eor;
    endian_timing_select ##0 s_lone_wr |=> !flags.eor [*2] ##1 flags.eor;
  endproperty
  property p_ft_eor;
    !endian_timing_select ##0 s_lone_wr |=> !flags.eor [*3] ##1 flags.eor;
  endproperty
  property p_in_ready_rise;
    endian_timing_select && !flags.full_or_input_ready_flag && flags.eor && rd_en
      && !$past(rd_en) && !$past(rd_en, 2) |=> !flags.full_or_input_ready_flag [*2]
      ##1 flags.full_or_input_ready_flag;
  endproperty
  property p_in_ready_fall;
    $fell(flags.full_or_input_ready_flag) |-> $past(wr_en) || $past(wr_en, 2);
  endproperty
  property p_aempty_rise; $rose(flags.almost_empty_flag) |-> $past(wr_en, 3); endproperty
  property p_afull_rise; $rose(flags.almost_full_flag) |-> $past(rd_en, 3); endproperty
  property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
  a_rst: assert property (p_rst) else $error("flags wrong after reset");
  a_std_eor: assert property (p_std_eor) else $error("empty flag latency");
  a_ft_eor: assert property (p_ft_eor) else $error("output ready latency");
  a_in_ready_rise: assert property (p_in_ready_rise) else $error("input ready latency");
  a_in_ready_fall: assert property (p_in_ready_fall) else $error("input ready fell");
  a_aempty_rise: assert property (p_aempty_rise) else $error("almost empty latency");
  a_afull_rise: assert property (p_afull_rise) else $error("almost full latency");
  a_apb: assert property (p_apb) else $error("ready not one cycle");
endmodule : fsf_asserts

bind fsf_top fsf_asserts i_fsf_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .endian_timing_select(endian_timing_select),
  .wr_en(wr_en), .rd_en(rd_en), .flags(flags));

// File: tb/fsf_far_end.sv
// Far-side write and read port controllers
`timescale 1ns/1ps
module fsf_far_end import fsf_pkg::*; (
  input  wire logic              pclk,     // Clock
  input  wire logic              std_mode, // Wanted mode
  input  wire logic              wr_req,   // Push
  input  wire logic [DATA_W-1:0] wr_word,  // Word
  input  wire logic              rd_req,   // Pop
  output logic                   endian_timing_select, // Strap
  output logic                   wr_en,    // Write
  output logic      [DATA_W-1:0] wr_data,  // Bus
  output logic                   rd_en     // Read
);
  initial begin
    endian_timing_select = 1'b0;
    wr_en = 1'b0;
    wr_data = '0;
    rd_en = 1'b0;
  end
  always @(posedge pclk) begin
    endian_timing_select <= std_mode;
    wr_en <= wr_req;
    wr_data <= wr_req ? wr_word : ~wr_data; // Idle bus inverts each cycle, so the last word returns every other idle cycle
    rd_en <= rd_req;
  end
endmodule : fsf_far_end

// File: tb/fifo_status_flag_logic_tb.sv
// Self-checking bench for the FIFO status flag block
`timescale 1ns/1ps
module fifo_status_flag_logic_tb import fsf_pkg::*;;
  localparam int D = 16;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic              endian_timing_select, wr_en, rd_en, wr_req, rd_req, std, took;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, seed, r;
  logic [DATA_W-1:0] wr_data, rd_data, wr_word, exp_w;
  logic [DATA_W-1:0] q[$];
  fsf_flags_s        flags;
  int                mismatches, n_tests, cyc;

  fsf_top #(.DEPTH(D), .AW(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .endian_timing_select(endian_timing_select),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .flags(flags));
  fsf_far_end i_far (.pclk(pclk), .std_mode(std), .wr_req(wr_req), .wr_word(wr_word),
    .rd_req(rd_req), .endian_timing_select(endian_timing_select), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en));

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task report_and_stop();
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic drive(input int n, input bit rnd, input bit w, input bit rd);
    logic [31:0] t;
    repeat (n) begin
      t = xs();
      wr_req <= rnd ? t[0] : w;
      rd_req <= rnd ? t[1] : rd;
      wr_word <= {t[7:4], xs()};
      @(posedge pclk);
    end
  endtask : drive
  // Words in RAM; fall-through keeps one in the output register
  task automatic settle();
    int ram;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    repeat (6) @(posedge pclk);
    ram = q.size() - int'(!std && q.size() != 0);
    check(flags.eor, q.size() != 0);
    check(flags.full_or_input_ready_flag, ram < D);
    check(flags.almost_empty_flag, ram > 3);
    check(flags.almost_full_flag, ram < D - 4);
    apb(1'b0, ADDR_FILL, 32'h0);
    check(r, DATA_W'(ram));
  endtask : settle

  always @(posedge pclk) if (presetn === 1'b1) begin
    if (wr_en && flags.full_or_input_ready_flag) q.push_back(wr_data);
    if (rd_en && flags.eor) begin
      took = std;
      exp_w = q.pop_front();
    end
  end
  always @(negedge pclk) begin
    if (took) check(rd_data, exp_w);
    else if (!std && flags.eor === 1'b1) check(rd_data, q.size() ? q[0] : ~rd_data);
    took = 1'b0;
  end
  always @(posedge pclk) if (++cyc > 5000) begin
    mismatches++;
    report_and_stop();
  end
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, wr_req, rd_req, wr_word, took} = '0;
    seed = 32'h0000_80CD;
    for (int m = 1; m >= 0; m--) begin
      std <= m[0];
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      q.delete();
      repeat (4) @(posedge pclk);
      apb(1'b1, ADDR_EMPTY_OFS, 32'h3);
      apb(1'b1, ADDR_FULL_OFS, 32'h4);
      apb(1'b0, ADDR_EMPTY_OFS, 32'h0);
      check(r, 3);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(r[ST_FALL_THROUGH_BIT], m == 0);
      apb(1'b0, 12'h010, 32'h0);
      check(e, 1);
      drive(1, 0, 1, 0);
      settle();
      drive(D + 2, 0, 1, 0);
      settle();
      drive(1, 0, 0, 1);
      settle();
      drive(300, 1, 0, 0);
      settle();
    end
    report_and_stop();
  end
endmodule : fifo_status_flag_logic_tb
